//--- rtl/grt16_timer.sv
// 16-bit period timer/counter with gate, prescaler and low-power oscillator mode
// assumes clk_sys is the instruction clock; pins and oscillator are asynchronous
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "grt16_regs.svh"

// Overview of operation
// R01 - internal mode counts each instruction cycle up to period, then zero
// R02 - external clock rising edges counted up to period, then restart at zero
// R03 - idle_stop is bit 13 of control
// R04 - gate, enable and internal source: count cycles only while gate pin high
// R05 - idle with idle_stop set halts counting; clear keeps counting
// R06 - prescaler divides by 1, 8, 64 or 256 via bits 5:4
// R07 - prescaler cleared on count write, enable clear, or reset
// R08 - prescaler otherwise frozen while disabled
// R09 - control writes leave count unchanged; only count writes change it
// R10 - sleep counting needs enable, external source and asynchronous setting
// R11 - in sleep keeps counting to period, wraps to zero, match may interrupt
// R12 - match sets flag, interrupt if enabled; only software clears flag
// R13 - gated mode also flags each gate falling edge
// R14 - oscillator mode counts 32 kHz oscillator rising edges to period
// R15 - software keeps ext_clock_sync zero for oscillator counting
// R16 - low_power_osc_enable disables normal modes, enables carry-out wake event
// R17 - oscillator counting continues in sleep while control unchanged
// R18 - flag in step reaching period; zero loaded on following step
// R19 - reset: period all ones, control zero, count undefined
module grt16_timer (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        gate_clock_pin,
  input  wire logic        lp_osc_clk,
  input  wire logic        idle_mode,
  input  wire logic        sleep_mode,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic        irq,
  output var  logic        wake_event
);

  grt16_pkg::grt16_ctrl_t ctrl;
  grt16_pkg::grt16_irq_t  status;
  grt16_pkg::grt16_irq_t  mask;
  logic [15:0] count;
  logic [15:0] period;
  logic [7:0]  pre_cnt;
  logic        lpen;
  logic        pin_s1, pin_s2, pin_s3;
  logic        lp_s1, lp_s2, lp_s3;
  logic        aw_got, w_got;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_wr;
  logic        wr_cnt, wr_per, wr_ctl, wr_st, wr_msk, wr_osc;
  logic [15:0] next_ctrl_word;
  logic        pin_rise, pin_fall, lp_rise;
  logic        tick, run, pre_hit, step;
  logic [15:0] next_count;
  logic        gate_fall;
  logic        match_evt;
  logic [7:0]  pre_lim;
  logic [31:0] rd_word;
  logic        rd_ok;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [15:0] ctrl_word(input grt16_pkg::grt16_ctrl_t c);
    logic [15:0] v;
    v = 16'h0000;
    v[`GRT_CTL_EN] = c.enable;
    v[`GRT_CTL_IDLE] = c.idle_stop;
    v[`GRT_CTL_GATE] = c.gate_accum;
    v[`GRT_CTL_PS_HI:`GRT_CTL_PS_LO] = c.ps;
    v[`GRT_CTL_SYNC] = c.ext_sync;
    v[`GRT_CTL_SRC] = c.src_sel;
    ctrl_word = v;
  endfunction : ctrl_word

  // pins are asynchronous to clk_sys, so even the asynchronous counter
  // mode samples its clock here; edges closer than one cycle merge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      lp_s1  <= 1'b0;
      lp_s2  <= 1'b0;
      lp_s3  <= 1'b0;
    end else if (clk_en) begin
      pin_s1 <= gate_clock_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      lp_s1  <= lp_osc_clk;
      lp_s2  <= lp_s1;
      lp_s3  <= lp_s2;
    end
  end

  assign pin_rise = pin_s2 & ~pin_s3;
  assign pin_fall = ~pin_s2 & pin_s3;
  assign lp_rise  = lp_s2 & ~lp_s3;

  // write channel: address and data taken in either order
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GRT_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got        <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_got && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_wr) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_cnt | wr_per | wr_ctl | wr_st | wr_msk | wr_osc) ?
                        `GRT_RESP_OKAY : `GRT_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign do_wr  = aw_got & w_got & ~s_axi_bvalid;
  assign wr_cnt = do_wr & (aw_addr == `GRT_ADR_COUNT);
  assign wr_per = do_wr & (aw_addr == `GRT_ADR_PERIOD);
  assign wr_ctl = do_wr & (aw_addr == `GRT_ADR_CTRL);
  assign wr_st  = do_wr & (aw_addr == `GRT_ADR_STATUS);
  assign wr_msk = do_wr & (aw_addr == `GRT_ADR_MASK);
  assign wr_osc = do_wr & (aw_addr == `GRT_ADR_OSC);
  assign next_ctrl_word = merge16(ctrl_word(ctrl), w_data, w_strb);

  // control, period, mask and oscillator registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl   <= '0;                                  // R19
      period <= `GRT_PER_RST;                        // R19
      mask   <= '0;
      lpen   <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctl) begin
        ctrl.enable     <= next_ctrl_word[`GRT_CTL_EN];
        ctrl.idle_stop  <= next_ctrl_word[`GRT_CTL_IDLE]; // R03
        ctrl.gate_accum <= next_ctrl_word[`GRT_CTL_GATE]; // R04
        ctrl.ps         <= next_ctrl_word[`GRT_CTL_PS_HI:`GRT_CTL_PS_LO]; // R06
        ctrl.ext_sync   <= next_ctrl_word[`GRT_CTL_SYNC];
        ctrl.src_sel    <= next_ctrl_word[`GRT_CTL_SRC];
      end
      if (wr_per) begin
        period <= merge16(period, w_data, w_strb);
      end
      if (wr_msk && w_strb[0]) begin
        mask <= w_data[`GRT_ST_WAKE:`GRT_ST_MATCH];
      end
      if (wr_osc && w_strb[0]) begin
        lpen <= w_data[`GRT_OSC_LPEN];
      end
    end
  end

  // count source selection
  always_comb begin
    if (!ctrl.src_sel) begin
      tick = lpen ? 1'b0 : (ctrl.gate_accum ? pin_s2 : 1'b1);  // R01 R04 R16
    end else begin
      tick = lpen ? lp_rise : pin_rise;                    // R02 R14
    end
  end

  // idle halts only with idle_stop; sleep needs the asynchronous external path
  assign run = ctrl.enable & ~(idle_mode & ctrl.idle_stop)            // R05
             & (~sleep_mode | (ctrl.src_sel & ~ctrl.ext_sync));       // R10 R11 R17

  always_comb begin
    unique case (ctrl.ps)
      2'b00:   pre_lim = `GRT_PRE_RST;
      2'b01:   pre_lim = `GRT_PS8_LIM;
      2'b10:   pre_lim = `GRT_PS64_LIM;
      2'b11:   pre_lim = `GRT_PS256_LIM;
    endcase
  end

  assign pre_hit = (pre_cnt == pre_lim);
  assign step    = clk_en & run & tick & pre_hit & ~wr_cnt;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pre_cnt <= `GRT_PRE_RST;                               // R07
    end else if (clk_en) begin
      // a control write clears only on a falling enable; a count write clears even a halted prescaler
      if (wr_cnt || (wr_ctl && ctrl.enable && !next_ctrl_word[`GRT_CTL_EN])) begin
        pre_cnt <= `GRT_PRE_RST;                             // R07
      end else if (run && tick) begin
        pre_cnt <= pre_hit ? `GRT_PRE_RST : pre_cnt + 8'h01; // R06 R08
      end
    end
  end

  assign next_count = (count == period) ? `GRT_CNT_RST : count + 16'h0001;

  // count is defined only once software writes it; zero here for convenience
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count <= `GRT_CNT_RST;                                 // R19
    end else if (clk_en) begin
      if (wr_cnt) begin
        count <= merge16(count, w_data, w_strb);             // R09
      end else if (step) begin
        count <= next_count;                                 // R01 R18
      end
    end
  end

  assign match_evt = step & (next_count == period);          // R18
  assign gate_fall = ctrl.enable & ctrl.gate_accum & ~ctrl.src_sel & ~lpen & pin_fall; // R13

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status <= '0;
    end else if (clk_en) begin
      status.match <= (match_evt & ~lpen) | gate_fall |           // R12 R13
                      (status.match & ~(wr_st & w_strb[0] & w_data[`GRT_ST_MATCH]));
      status.wake  <= (match_evt & lpen) |                        // R16
                      (status.wake & ~(wr_st & w_strb[0] & w_data[`GRT_ST_WAKE]));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq        <= 1'b0;
      wake_event <= 1'b0;
    end else if (clk_en) begin
      irq        <= |(status & mask);                             // R12
      wake_event <= match_evt & lpen;                             // R16
    end
  end

  // read side
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      `GRT_ADR_COUNT:  rd_word[15:0] = count;
      `GRT_ADR_PERIOD: rd_word[15:0] = period;
      `GRT_ADR_CTRL:   rd_word[15:0] = ctrl_word(ctrl);
      `GRT_ADR_STATUS: rd_word[`GRT_ST_WAKE:`GRT_ST_MATCH] = status;
      `GRT_ADR_MASK:   rd_word[`GRT_ST_WAKE:`GRT_ST_MATCH] = mask;
      `GRT_ADR_OSC:    rd_word[`GRT_OSC_LPEN] = lpen;
      default:         rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `GRT_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `GRT_RESP_OKAY : `GRT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  property p_count_inc;
    @(posedge clk_sys) disable iff (!reset_n)
    (step && count != period) |=> count == $past(count) + 16'h0001;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count did not advance"); // R01
  property p_wrap;
    @(posedge clk_sys) disable iff (!reset_n)
    (step && count == period) |=> count == `GRT_CNT_RST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap"); // R18
  property p_ctl_keeps_count;
    @(posedge clk_sys) disable iff (!reset_n)
    (wr_ctl && !step) |=> count == $past(count);
  endproperty
  a_ctl_keeps_count: assert property (p_ctl_keeps_count) else $error("control write moved count"); // R09
  property p_pre_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && wr_cnt) |=> pre_cnt == `GRT_PRE_RST;
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared"); // R07
  property p_pre_frozen;
    @(posedge clk_sys) disable iff (!reset_n)
    (!ctrl.enable && !wr_cnt) |=> $stable(pre_cnt);
  endproperty
  a_pre_frozen: assert property (p_pre_frozen) else $error("prescaler moved while off"); // R08
  property p_idle_halt;
    @(posedge clk_sys) disable iff (!reset_n)
    (idle_mode && ctrl.idle_stop) |-> !step;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("counted during idle stop"); // R05
  property p_sleep_gate;
    @(posedge clk_sys) disable iff (!reset_n)
    (sleep_mode && !(ctrl.src_sel && !ctrl.ext_sync)) |-> !step;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("counted in sleep"); // R10
  property p_gate_low;
    @(posedge clk_sys) disable iff (!reset_n)
    (ctrl.gate_accum && !ctrl.src_sel && !pin_s2) |-> !step;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("counted with gate low"); // R04
  property p_gate_fall_flag;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && gate_fall) |=> status.match;
  endproperty
  a_gate_fall_flag: assert property (p_gate_fall_flag) else $error("gate fall not flagged"); // R13
  property p_flag_sticky;
    @(posedge clk_sys) disable iff (!reset_n)
    (status.match && !wr_st) |=> status.match;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by itself"); // R12
  property p_irq_out;
    @(posedge clk_sys) disable iff (!reset_n)
    (clk_en && |(status & mask)) |=> irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt missing"); // R12
  property p_lp_wake;
    @(posedge clk_sys) disable iff (!reset_n)
    (lpen && match_evt) |=> wake_event ##1 (!wake_event || $past(match_evt));
  endproperty
  a_lp_wake: assert property (p_lp_wake) else $error("wake event missing"); // R16
  property p_lp_no_internal;
    @(posedge clk_sys) disable iff (!reset_n)
    (lpen && !ctrl.src_sel) |-> !step;
  endproperty
  a_lp_no_internal: assert property (p_lp_no_internal) else $error("internal count with osc"); // R16
  property p_reset_vals;
    @(posedge clk_sys)
    (!reset_n && clk_en) |=> (period == `GRT_PER_RST && ctrl == '0);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // R19

endmodule : grt16_timer
`default_nettype wire

//--- rtl/grt16_regs.svh
// register map, field positions, reset values and limits of the 16-bit timer
// assumes a 12-bit byte address on the register bus
`ifndef GRT16_REGS_SVH
`define GRT16_REGS_SVH
// register indices, byte address is four times the index
`define GRT_IDX_COUNT   16'h0100
`define GRT_IDX_PERIOD  16'h0102
`define GRT_IDX_CTRL    16'h0104
`define GRT_IDX_STATUS  16'h0106
`define GRT_IDX_MASK    16'h0108
`define GRT_IDX_OSC     16'h010a
`define GRT_ADR_COUNT   12'h400
`define GRT_ADR_PERIOD  12'h408
`define GRT_ADR_CTRL    12'h410
`define GRT_ADR_STATUS  12'h418
`define GRT_ADR_MASK    12'h420
`define GRT_ADR_OSC     12'h428
// control field positions
`define GRT_CTL_EN      15
`define GRT_CTL_IDLE    13
`define GRT_CTL_GATE    6
`define GRT_CTL_PS_HI   5
`define GRT_CTL_PS_LO   4
`define GRT_CTL_SYNC    2
`define GRT_CTL_SRC     1
`define GRT_OSC_LPEN    1
// status and mask bits
`define GRT_ST_MATCH    0
`define GRT_ST_WAKE     1
// reset values
`define GRT_PER_RST     16'hffff
`define GRT_CNT_RST     16'h0000
`define GRT_PRE_RST     8'h00
// prescaler terminal counts for 1:8, 1:64, 1:256
`define GRT_PS8_LIM     8'h07
`define GRT_PS64_LIM    8'h3f
`define GRT_PS256_LIM   8'hff
// bus answers
`define GRT_RESP_OKAY   2'b00
`define GRT_RESP_SLVERR 2'b10
`endif

//--- rtl/grt16_pkg.sv
// types shared by the 16-bit timer
// constants live in grt16_regs.svh
package grt16_pkg;
  typedef struct packed {
    logic       enable;
    logic       idle_stop;
    logic       gate_accum;
    logic [1:0] ps;
    logic       ext_sync;
    logic       src_sel;
  } grt16_ctrl_t;
  typedef struct packed {
    logic wake;
    logic match;
  } grt16_irq_t;
endpackage : grt16_pkg

//--- verification/grt16_pins_model.sv
// pin-side model: external clock / gate pin and the low-power oscillator
// assumes clk_sys from the bench; the bench calls pulses() and drives osc_on
`timescale 1ns/1ps
`default_nettype none
module grt16_pins_model #(
  parameter int OSC_HALF = 6
) (
  input  wire logic clk_sys,
  input  wire logic osc_on,
  output var  logic gate_clock_pin,
  output var  logic lp_osc_clk
);
  int oc;
  initial begin
    gate_clock_pin = 1'b0;
    lp_osc_clk = 1'b0;
    oc = 0;
  end
  // a stopped crystal holds its last level, low until first started; the real 32 kHz rate is shortened to keep runs brief
  always @(posedge clk_sys) begin
    if (osc_on) begin
      oc = (oc + 1) % OSC_HALF;
      if (oc == 0) lp_osc_clk <= ~lp_osc_clk;
    end
  end
  // every level lasts at least two clocks so the synchroniser cannot miss it
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge clk_sys);
      gate_clock_pin <= 1'b1;
      repeat (hi) @(posedge clk_sys);
      gate_clock_pin <= 1'b0;
      repeat (lo - 1) @(posedge clk_sys);
    end
  endtask : pulses
endmodule : grt16_pins_model
`default_nettype wire

//--- verification/gated_rtc_timer16_bench.sv
// self-checking bench of the 16-bit gated timer over AXI4-Lite
// assumes grt16_timer and grt16_pins_model; single 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "grt16_regs.svh"
module gated_rtc_timer16_bench;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        idle_mode = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        osc_on = 1'b0;
  logic        gate_clock_pin;
  logic        lp_osc_clk;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        irq;
  logic        wake_event;
  logic [31:0] rdat;
  logic [31:0] v;
  logic [31:0] c1;
  logic [1:0]  last_resp;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          seed;
  int          cyc = 0;
  int          b_cyc;
  int          wake_seen = 0;
  int          i;
  int          t0;
  int          e;
  int          hi;

  grt16_timer i_grt16_timer (.clk_sys, .reset_n, .clk_en, .gate_clock_pin, .lp_osc_clk,
    .idle_mode, .sleep_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .wake_event);
  grt16_pins_model i_grt16_pins_model (.clk_sys, .osc_on, .gate_clock_pin, .lp_osc_clk);

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (wake_event === 1'b1) wake_seen <= wake_seen + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chk_rng(input logic [31:0] seen, input int lo, input int hi);
    logic ok;
    ok = (seen >= lo) && (seen <= hi);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %0d outside %0d..%0d", $time, seen, lo, hi);
    end
  endtask : chk_rng
  task automatic bus_to(input int n);
    if (n >= 100) begin
      error_cnt++;
      $display("CHECK FAILED %0t bus answer missing", $time);
    end
  endtask : bus_to
  // address and data offered together; each released at the edge it is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    last_resp = s_axi_bresp;
    b_cyc = cyc;
    s_axi_bready <= 1'b0;
    bus_to(n);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    rdat = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    bus_to(n);
  endtask : rd
  function automatic logic [31:0] f_ctl(input grt16_pkg::grt16_ctrl_t c);
    f_ctl = 32'h0;
    f_ctl[`GRT_CTL_EN] = c.enable;
    f_ctl[`GRT_CTL_IDLE] = c.idle_stop;
    f_ctl[`GRT_CTL_GATE] = c.gate_accum;
    f_ctl[`GRT_CTL_PS_HI:`GRT_CTL_PS_LO] = c.ps;
    f_ctl[`GRT_CTL_SYNC] = c.ext_sync;
    f_ctl[`GRT_CTL_SRC] = c.src_sel;
  endfunction : f_ctl
  function automatic int f_div(input int ps);
    f_div = (ps == 0) ? 1 : (ps == 1) ? 8 : (ps == 2) ? 64 : 256;
  endfunction : f_div
  task automatic restart(input logic [31:0] per, input logic [6:0] c);
    wr(`GRT_ADR_CTRL, 32'h0);
    wr(`GRT_ADR_STATUS, 32'h3);
    wr(`GRT_ADR_PERIOD, per);
    wr(`GRT_ADR_COUNT, 32'h0);
    wr(`GRT_ADR_CTRL, f_ctl(c));
  endtask : restart
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    #2000000;
    error_cnt++;
    complete_run();
  end

  initial begin
    seed = 32'he879;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`GRT_ADR_PERIOD);
    chk(rdat, 32'h0000ffff);
    rd(`GRT_ADR_CTRL);
    chk(rdat, 32'h0);
    rd(12'h7fc);
    chk({30'h0, last_resp}, {30'h0, `GRT_RESP_SLVERR});
    wr(12'h7fc, 32'h1);
    chk({30'h0, last_resp}, {30'h0, `GRT_RESP_SLVERR});
    // control writes with the counter stopped must not disturb the count
    wr(`GRT_ADR_COUNT, 32'h0000a5c3);
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'h00002000 : ($random(seed) & 32'h00002076);
      wr(`GRT_ADR_CTRL, v);
      rd(`GRT_ADR_CTRL);
      chk(rdat, v);
      rd(`GRT_ADR_COUNT);
      chk(rdat, 32'h0000a5c3);
    end
    // every prescale code over a measured enable span
    for (i = 0; i < 4; i++) begin
      restart(32'hffff, {3'h4, i[1:0], 2'h0});
      t0 = b_cyc;
      repeat (500 + ($random(seed) & 63)) @(posedge clk_sys);
      wr(`GRT_ADR_CTRL, f_ctl({3'h0, i[1:0], 2'h0}));
      e = (b_cyc - t0) / f_div(i);
      rd(`GRT_ADR_COUNT);
      chk_rng(rdat, e - 1, e + 1);
    end
    // synchronous external count through the period and the wrap
    restart(32'h3, 7'h43);
    wr(`GRT_ADR_MASK, 32'h1);
    for (i = 1; i <= 4; i++) begin
      i_grt16_pins_model.pulses(1, 3, 3);
      repeat (6) @(posedge clk_sys);
      rd(`GRT_ADR_COUNT);
      chk(rdat, i % 4);
      rd(`GRT_ADR_STATUS);
      chk(rdat[0], i >= 3);
      chk(irq, i >= 3);
    end
    repeat (30) @(posedge clk_sys);
    rd(`GRT_ADR_STATUS);
    chk(rdat[0], 1'b1);
    wr(`GRT_ADR_STATUS, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b0);
    // gated accumulation: count only while the gate is high, flag at its fall
    restart(32'hffff, 7'h50);
    repeat (20) @(posedge clk_sys);
    rd(`GRT_ADR_COUNT);
    chk(rdat, 32'h0);
    hi = 60 + ($random(seed) & 15);
    i_grt16_pins_model.pulses(1, hi, 8);
    repeat (8) @(posedge clk_sys);
    rd(`GRT_ADR_COUNT);
    chk_rng(rdat, hi - 3, hi + 3);
    rd(`GRT_ADR_STATUS);
    chk(rdat[0], 1'b1);
    chk(irq, 1'b1);
    wr(`GRT_ADR_MASK, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'b0);
    // idle with and without idle_stop
    idle_mode <= 1'b1;
    restart(32'hffff, 7'h60);
    rd(`GRT_ADR_COUNT);
    c1 = rdat;
    repeat (40) @(posedge clk_sys);
    rd(`GRT_ADR_COUNT);
    chk(rdat, c1);
    wr(`GRT_ADR_CTRL, f_ctl(7'h40));
    repeat (40) @(posedge clk_sys);
    rd(`GRT_ADR_COUNT);
    chk_rng(rdat, c1 + 40, c1 + 200);
    // clock enable low freezes the whole block, bus included
    rd(`GRT_ADR_COUNT);
    c1 = rdat;
    clk_en <= 1'b0;
    repeat (30) @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(`GRT_ADR_COUNT);
    chk_rng(rdat, c1 + 1, c1 + 20);
    idle_mode <= 1'b0;
    // sleep: internal source stops, asynchronous external keeps going
    sleep_mode <= 1'b1;
    restart(32'hffff, 7'h40);
    repeat (40) @(posedge clk_sys);
    rd(`GRT_ADR_COUNT);
    chk(rdat, 32'h0);
    restart(32'h3, 7'h41);
    i_grt16_pins_model.pulses(5, 3, 3);
    repeat (6) @(posedge clk_sys);
    rd(`GRT_ADR_COUNT);
    chk(rdat, 32'h1);
    rd(`GRT_ADR_STATUS);
    chk(rdat[0], 1'b1);
    wr(`GRT_ADR_CTRL, f_ctl(7'h43));
    i_grt16_pins_model.pulses(2, 3, 3);
    repeat (6) @(posedge clk_sys);
    rd(`GRT_ADR_COUNT);
    chk(rdat, 32'h1);
    // low-power oscillator mode: normal modes off, wake event on period match
    sleep_mode <= 1'b0;
    wr(`GRT_ADR_OSC, 32'h2);
    restart(32'hffff, 7'h40);
    repeat (40) @(posedge clk_sys);
    rd(`GRT_ADR_COUNT);
    chk(rdat, 32'h0);
    restart(32'h3, 7'h41);
    sleep_mode <= 1'b1;
    osc_on <= 1'b1;
    repeat (110) @(posedge clk_sys);
    rd(`GRT_ADR_COUNT);
    // nine oscillator rises land before the read: 1,2,3,0,1,2,3,0,1
    chk(rdat, 32'h1);
    rd(`GRT_ADR_STATUS);
    chk(rdat, 32'h2);
    chk_rng(wake_seen, 2, 2);
    complete_run();
  end
endmodule : gated_rtc_timer16_bench
`default_nettype wire
